/* File: ditt_engine.sv */
// digital input sample clock, trigger engine and acquisition fifo with apb registers
//
// Contract
// - each sample clock edge stores one sample
// - sample edge on full fifo flags overflow
// - sample clock from divided timebase or external terminal
// - sample edge polarity is selectable
// - routed sample clock output is inverted
// - start on trigger, else software start
// - finite count, reference, or software stop
// - programmable delay start to first sample; not applied with external sample clock
// - digital start from terminal, edge selectable
// - analog start on rising comparison edge
// - time source for start only
// - routed start trigger is active high pulse
// - posttrigger equals buffer minus pretrigger
// - ignore reference before pretrigger count reached
// - discard oldest sample while buffer full
// - stop after posttrigger count stored
// - analog reference edge is selectable
// - reference output active high by default
// - active pause halts internal sample clock
// - pause active level selectable
// - pause is level sensitive only
// - optional glitch filter on timing inputs
// - filter passes level after consecutive samples
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "ditt_params.svh"
module ditt_engine (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  i_module_function_terminal,
  input  wire logic        i_analog_compare,
  input  wire logic        i_ext_timebase,
  input  wire logic [31:0] i_channels,
  output logic             o_sample_clock_out,
  output logic             o_start_trigger_out,
  output logic             o_reference_trigger_out,
  output logic             o_running
);
  // ==========================================================
  // registers
  logic [31:0] ctrl_r, src_r, div_r, delay_r, count_r, pre_r, time_r, flt_r;
  logic        overflow_r;
  logic        ref_seen_r;
  logic [31:0] time_now_r;
  ditt_pkg::ditt_state_e state_r;
  logic [`DITT_FIFO_AW:0] fill_r;
  logic [`DITT_FIFO_AW-1:0] wptr_r, rptr_r;
  logic [31:0] mem_rdata;
  logic        acc_wr, acc_rd, pop;
  logic        sw_start, sw_stop;

  assign acc_wr   = psel && penable && pwrite;
  assign acc_rd   = psel && penable && !pwrite;
  assign sw_start = acc_wr && (paddr == `DITT_CTRL_OFS) && pwdata[`DITT_C_START];
  assign sw_stop  = acc_wr && (paddr == `DITT_CTRL_OFS) && pwdata[`DITT_C_STOP];
  assign pop      = acc_rd && (paddr == `DITT_DATA_OFS) && (fill_r != '0);

  // ==========================================================
  // input synchronisers, two flops per line
  logic [10:0] raw_in, sync1_r, sync2_r;
  assign raw_in = {i_ext_timebase, i_analog_compare, i_module_function_terminal, 1'b0};
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // glitch filter: level must be seen on consecutive filter ticks
  logic [15:0] fdiv_r;
  logic        ftick;
  logic [10:0] fprev_r, filt_r, clean;
  assign ftick = (fdiv_r == flt_r[15:0]);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      fdiv_r  <= '0;
      fprev_r <= '0;
      filt_r  <= '0;
    end else begin
      fdiv_r <= ftick ? 16'h0000 : fdiv_r + 16'h0001;
      if (ftick) begin
        fprev_r <= sync2_r;
        filt_r  <= (sync2_r & fprev_r) | (filt_r & (sync2_r | fprev_r));
      end
    end
  end
  assign clean = ctrl_r[`DITT_C_FLT_EN] ? filt_r : sync2_r;

  // source select helper: bit 0 spare, bits 1..8 terminals, bit 9 analog, bit 10 timebase
  function automatic logic pick(input logic [1:0] kind, input logic [2:0] sel, input logic [10:0] v);
    logic r;
    r = 1'b0;
    if (kind == ditt_pkg::DITT_TRG_DIGITAL) begin
      r = v[4'(sel) + 4'h1];
    end else if (kind == ditt_pkg::DITT_TRG_ANALOG) begin
      r = v[9];
    end
    return r;
  endfunction

  logic st_lvl, rf_lvl, ps_lvl, st_prev_r, rf_prev_r, tb_prev_r;
  assign st_lvl = pick(src_r[1:0], src_r[4:2], clean);
  assign rf_lvl = pick(src_r[6:5], src_r[9:7], clean);
  assign ps_lvl = pick(src_r[11:10], src_r[14:12], clean);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_prev_r <= 1'b0;
      rf_prev_r <= 1'b0;
      tb_prev_r <= 1'b0;
    end else begin
      st_prev_r <= st_lvl;
      rf_prev_r <= rf_lvl;
      tb_prev_r <= clean[10];
    end
  end

  // start event: analog always rising, digital by edge choice, time on match
  logic st_fire, rf_edge, paused;
  always_comb begin
    st_fire = 1'b0;
    case (src_r[1:0])
      ditt_pkg::DITT_TRG_NONE:    st_fire = sw_start;
      ditt_pkg::DITT_TRG_ANALOG:  st_fire = st_lvl && !st_prev_r;
      ditt_pkg::DITT_TRG_TIME:    st_fire = (time_now_r == time_r);
      default:                    st_fire = ctrl_r[`DITT_C_ST_FALL] ? (!st_lvl && st_prev_r)
                                                                    : (st_lvl && !st_prev_r);
    endcase
  end
  assign rf_edge = ctrl_r[`DITT_C_RF_FALL] ? (!rf_lvl && rf_prev_r) : (rf_lvl && !rf_prev_r);
  // pause compares a level, never an edge; a time kind acts as none
  assign paused = (src_r[11] ^ src_r[10])
                  && (ps_lvl == !ctrl_r[`DITT_C_PS_LOW]);

  // ==========================================================
  // timebase and divider
  logic        tb_tick, div_tick, clk_lvl_r, clk_prev_r, samp_edge;
  logic [31:0] div_cnt_r;
  assign tb_tick = ctrl_r[`DITT_C_TB_EXT] ? (clean[10] && !tb_prev_r) : 1'b1;
  assign div_tick = tb_tick && (div_cnt_r == '0);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_r <= '0;
      clk_lvl_r <= 1'b0;
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= clk_lvl_r;
      if (state_r == ditt_pkg::DITT_IDLE) begin
        div_cnt_r <= div_r;
        clk_lvl_r <= 1'b0;
      end else if (tb_tick && !(paused && !ctrl_r[`DITT_C_CLK_EXT])) begin
        // half period per toggle keeps a square internal clock
        div_cnt_r <= (div_cnt_r == '0) ? div_r : div_cnt_r - 32'h0000_0001;
        if (div_tick) begin
          clk_lvl_r <= !clk_lvl_r;
        end
      end
    end
  end
  // external clock is the selected start-style source line
  logic ext_lvl, ext_prev_r, cur_lvl, cur_prev;
  assign ext_lvl = clean[4'(src_r[17:15]) + 4'h1];
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_lvl;
    end
  end
  assign cur_lvl  = ctrl_r[`DITT_C_CLK_EXT] ? ext_lvl : clk_lvl_r;
  assign cur_prev = ctrl_r[`DITT_C_CLK_EXT] ? ext_prev_r : clk_prev_r;
  // an external clock is gated by pause too so no sample lands while paused
  assign samp_edge = (ctrl_r[`DITT_C_CLK_FALL] ? (!cur_lvl && cur_prev) : (cur_lvl && !cur_prev))
                     && !paused;

  // ==========================================================
  // acquisition sequencer
  logic [31:0] taken_r, post_r, dly_r;
  logic        store, full, sampling;
  ditt_pkg::ditt_end_e endm;
  assign endm     = ditt_pkg::ditt_end_e'(ctrl_r[5:4]);
  assign full     = (fill_r == (`DITT_FIFO_AW+1)'(`DITT_FIFO_DEPTH));
  assign sampling = (state_r == ditt_pkg::DITT_RUN) || (state_r == ditt_pkg::DITT_POST);
  assign store    = sampling && samp_edge;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r    <= ditt_pkg::DITT_IDLE;
      taken_r    <= '0;
      post_r     <= '0;
      dly_r      <= '0;
      ref_seen_r <= 1'b0;
    end else if (sw_stop) begin
      state_r <= ditt_pkg::DITT_IDLE;
    end else begin
      case (state_r)
        ditt_pkg::DITT_IDLE: begin
          taken_r <= '0;
          dly_r   <= delay_r;
          if (st_fire) begin
            ref_seen_r <= 1'b0;
            state_r <= (!ctrl_r[`DITT_C_CLK_EXT] && delay_r != '0) ? ditt_pkg::DITT_DELAY
                                                                     : ditt_pkg::DITT_RUN;
          end
        end
        ditt_pkg::DITT_DELAY: begin
          if (tb_tick) begin
            dly_r <= dly_r - 32'h0000_0001;
            if (dly_r == 32'h0000_0001) begin
              state_r <= ditt_pkg::DITT_RUN;
            end
          end
        end
        ditt_pkg::DITT_RUN: begin
          if (store) begin
            taken_r <= taken_r + 32'h0000_0001;
          end
          if (endm == ditt_pkg::DITT_END_COUNT && store && taken_r + 32'h0000_0001 >= count_r) begin
            state_r <= ditt_pkg::DITT_IDLE;
          end else if (endm == ditt_pkg::DITT_END_REF && rf_edge && taken_r >= pre_r) begin
            ref_seen_r <= 1'b1;
            post_r  <= count_r - pre_r;
            state_r <= (count_r == pre_r) ? ditt_pkg::DITT_IDLE : ditt_pkg::DITT_POST;
          end
        end
        default: begin
          if (store) begin
            post_r <= post_r - 32'h0000_0001;
            if (post_r == 32'h0000_0001) begin
              state_r <= ditt_pkg::DITT_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // fifo pointers; reference mode overwrites oldest once count_r samples are held or the fifo is full
  logic wr_en, drop;
  assign drop  = store && (full || 32'(fill_r) >= count_r) && (endm == ditt_pkg::DITT_END_REF) && sampling;
  assign wr_en = store && (!full || drop);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_r     <= '0;
      rptr_r     <= '0;
      fill_r     <= '0;
      overflow_r <= 1'b0;
    end else begin
      if (wr_en) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop || drop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (wr_en && !(pop || drop)) begin
        fill_r <= fill_r + 1'b1;
      end else if (!wr_en && pop) begin
        fill_r <= fill_r - 1'b1;
      end
      // set wins over clear
      if (store && full && !drop) begin
        overflow_r <= 1'b1;
      end else if (acc_wr && paddr == `DITT_CTRL_OFS && pwdata[`DITT_C_CLR_OVF]) begin
        overflow_r <= 1'b0;
      end
    end
  end

  ditt_fifo_mem #(.AW(`DITT_FIFO_AW), .DW(32)) u_mem (
    .i_clock (i_clock),
    .i_wr    (wr_en),
    .i_waddr (wptr_r),
    .i_wdata (i_channels),
    .i_raddr (rptr_r),
    .o_rdata (mem_rdata)
  );

  // ==========================================================
  // apb register writes and free-running time
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= '0;
      src_r  <= '0;
      div_r  <= `DITT_DIV_RST;
      delay_r <= '0;
      count_r <= '0;
      pre_r  <= '0;
      time_r <= '0;
      flt_r  <= `DITT_FLT_RST;
      time_now_r <= '0;
    end else begin
      time_now_r <= time_now_r + 32'h0000_0001;
      if (acc_wr) begin
        if (paddr == `DITT_CTRL_OFS) begin
          ctrl_r <= pwdata & 32'h0000_3FF0; // command bits self clear
        end else if (paddr == `DITT_SRC_OFS) begin
          src_r <= pwdata;
        end else if (paddr == `DITT_DIV_OFS) begin
          div_r <= pwdata;
        end else if (paddr == `DITT_DELAY_OFS) begin
          delay_r <= pwdata;
        end else if (paddr == `DITT_COUNT_OFS) begin
          count_r <= pwdata;
        end else if (paddr == `DITT_PRE_OFS) begin
          pre_r <= pwdata;
        end else if (paddr == `DITT_TIME_OFS) begin
          time_r <= pwdata;
        end else if (paddr == `DITT_FLT_OFS) begin
          flt_r <= pwdata;
        end
      end
    end
  end

  // read phase: setup cycle latches, access cycle answers (no wait state)
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `DITT_DATA_OFS || paddr[1:0] != 2'b00);
      if (psel && !penable) begin
        if (paddr == `DITT_CTRL_OFS) begin
          prdata <= ctrl_r;
        end else if (paddr == `DITT_SRC_OFS) begin
          prdata <= src_r;
        end else if (paddr == `DITT_DIV_OFS) begin
          prdata <= div_r;
        end else if (paddr == `DITT_DELAY_OFS) begin
          prdata <= delay_r;
        end else if (paddr == `DITT_COUNT_OFS) begin
          prdata <= count_r;
        end else if (paddr == `DITT_PRE_OFS) begin
          prdata <= pre_r;
        end else if (paddr == `DITT_TIME_OFS) begin
          prdata <= time_r;
        end else if (paddr == `DITT_STATUS_OFS) begin
          prdata <= {26'h0, paused, full, ref_seen_r, overflow_r, 2'(state_r)};
        end else if (paddr == `DITT_STORED_OFS) begin
          prdata <= 32'(fill_r);
        end else if (paddr == `DITT_TIMENOW_OFS) begin
          prdata <= time_now_r;
        end else if (paddr == `DITT_FLT_OFS) begin
          prdata <= flt_r;
        end else if (paddr == `DITT_DATA_OFS) begin
          prdata <= mem_rdata;
        end else begin
          prdata <= '0;
        end
      end
    end
  end

  // ==========================================================
  // routed outputs
  logic [3:0] st_pulse_r;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sample_clock_out      <= 1'b1;
      o_start_trigger_out     <= 1'b0;
      o_reference_trigger_out <= 1'b0;
      o_running               <= 1'b0;
      st_pulse_r              <= '0;
    end else begin
      o_sample_clock_out <= !(sampling && cur_lvl);
      if (state_r == ditt_pkg::DITT_IDLE && st_fire) begin
        st_pulse_r <= `DITT_PULSE_CYC;
      end else if (st_pulse_r != '0) begin
        st_pulse_r <= st_pulse_r - 4'h1;
      end
      o_start_trigger_out <= (st_pulse_r != '0);
      o_reference_trigger_out <= ref_seen_r ^ ctrl_r[`DITT_C_RF_OUTLOW];
      o_running <= sampling;
    end
  end
endmodule

/* File: ditt_params.svh */
// constants for the digital input trigger and timing engine
`ifndef DITT_PARAMS_SVH
`define DITT_PARAMS_SVH
// register byte offsets
`define DITT_CTRL_OFS     12'h000
`define DITT_SRC_OFS      12'h004
`define DITT_DIV_OFS      12'h008
`define DITT_DELAY_OFS    12'h00C
`define DITT_COUNT_OFS    12'h010
`define DITT_PRE_OFS      12'h014
`define DITT_TIME_OFS     12'h018
`define DITT_STATUS_OFS   12'h01C
`define DITT_STORED_OFS   12'h020
`define DITT_TIMENOW_OFS  12'h024
`define DITT_FLT_OFS      12'h028
`define DITT_DATA_OFS     12'h02C
// control register fields
`define DITT_C_START      0
`define DITT_C_STOP       1
`define DITT_C_CLR_OVF    2
`define DITT_C_MODE_LO    4
`define DITT_C_CLK_EXT    6
`define DITT_C_CLK_FALL   7
`define DITT_C_TB_EXT     8
`define DITT_C_ST_FALL    9
`define DITT_C_RF_FALL    10
`define DITT_C_PS_LOW     11
`define DITT_C_RF_OUTLOW  12
`define DITT_C_FLT_EN     13
// source register fields: start kind [1:0], start sel [4:2], ref kind [6:5], ref sel [9:7], pause kind, pause sel
`define DITT_S_SK_LO      0
`define DITT_S_SS_LO      2
`define DITT_S_RK_LO      5
`define DITT_S_RS_LO      7
`define DITT_S_PK_LO      10
`define DITT_S_PS_LO      12
// reset values
`define DITT_DIV_RST      32'h0000_0009
`define DITT_FLT_RST      32'h0000_0003
// fifo depth
`define DITT_FIFO_AW      8
`define DITT_FIFO_DEPTH   256
// start pulse output width in cycles
`define DITT_PULSE_CYC    4'h4
`endif

/* File: ditt_pkg.sv */
// types for the digital input trigger and timing engine
package ditt_pkg;
  typedef enum logic [1:0] {
    DITT_IDLE    = 2'b00,
    DITT_DELAY   = 2'b01,
    DITT_RUN     = 2'b10,
    DITT_POST    = 2'b11
  } ditt_state_e;
  typedef enum logic [1:0] {
    DITT_END_COUNT = 2'b00,
    DITT_END_REF   = 2'b01,
    DITT_END_CONT  = 2'b10
  } ditt_end_e;
  typedef enum logic [1:0] {
    DITT_TRG_NONE    = 2'b00,
    DITT_TRG_DIGITAL = 2'b01,
    DITT_TRG_ANALOG  = 2'b10,
    DITT_TRG_TIME    = 2'b11
  } ditt_trig_e;
endpackage

/* File: ditt_fifo_mem.sv */
// sample storage memory with registered read data
module ditt_fifo_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input  wire logic          i_clock,
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array so it maps to block ram
  always_ff @(posedge i_clock) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

/* File: ditt_engine_checker.sv */
// bus and timing assertions for the trigger engine
module ditt_engine_checker (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        o_sample_clock_out,
  input wire logic        o_start_trigger_out,
  input wire logic        o_running
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // register bus answers
  logic setup;
  logic bad_addr;
  // misaligned or past the last word is refused
  assign setup = psel && !penable;
  assign bad_addr = (paddr > 12'h02C) || (paddr[1:0] != 2'b00);
  sequence s_refused;
    pready && pslverr && (prdata == 32'h0000_0000);
  endsequence
  sequence s_accepted;
    pready && !pslverr;
  endsequence
  chk_pready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_after_setup: assert property (pready |-> $past(setup))
    else $error("pready without a setup cycle before it");
  chk_mapped_answer: assert property (setup && !bad_addr |=> s_accepted)
    else $error("mapped access not answered cleanly");
  chk_unmapped_refused: assert property (setup && bad_addr |=> s_refused)
    else $error("unmapped access not refused with zero data");
  chk_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  // ==========================================================
  // trigger and clock outputs
  sequence s_pulse4;
    o_start_trigger_out [*4] ##1 !o_start_trigger_out;
  endsequence
  chk_start_pulse_width: assert property ($rose(o_start_trigger_out) |-> s_pulse4)
    else $error("start pulse not four cycles wide");
  chk_sclk_idle_high: assert property ((!o_running) [*3] |-> o_sample_clock_out)
    else $error("sample clock output low while idle");
  chk_sclk_low_running: assert property ($fell(o_sample_clock_out) |-> o_running || $past(o_running))
    else $error("sample clock output pulsed outside a run");
  cover property ($rose(o_running));
endmodule

bind ditt_engine ditt_engine_checker u_chk (
  .i_clock            (i_clock),
  .i_rstn             (i_rstn),
  .psel               (psel),
  .penable            (penable),
  .paddr              (paddr),
  .prdata             (prdata),
  .pready             (pready),
  .pslverr            (pslverr),
  .o_sample_clock_out (o_sample_clock_out),
  .o_start_trigger_out(o_start_trigger_out),
  .o_running          (o_running)
);

/* File: ditt_module_model.sv */
// behavioural model of the plug-in modules feeding the engine
module ditt_module_model (
  input  wire logic        i_clock,
  input  wire logic [7:0]  i_term_req,
  input  wire logic        i_cmp_req,
  input  wire logic [31:0] i_data_req,
  output logic      [7:0]  o_terminal,
  output logic             o_compare,
  output logic      [31:0] o_channels,
  output logic             o_timebase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  term_r = 8'h00;
  logic        cmp_r = 1'b0;
  logic [31:0] chan_r = 32'h0000_0000;
  logic [1:0]  tb_cnt_r = 2'b00;
  logic        tb_r = 1'b0;
  // pins move just after the edge, like a module launched from the same timebase
  always @(posedge i_clock) begin
    term_r <= i_term_req;
    cmp_r <= i_cmp_req;
    chan_r <= i_data_req;
  end
  // free-running external timebase at a sixth of the clock; the engine must sync it
  always @(posedge i_clock) begin
    tb_cnt_r <= (tb_cnt_r == 2'b10) ? 2'b00 : tb_cnt_r + 2'b01;
    if (tb_cnt_r == 2'b10) begin
      tb_r <= ~tb_r;
    end
  end
  assign o_terminal = term_r;
  assign o_compare = cmp_r;
  assign o_channels = chan_r;
  assign o_timebase = tb_r;
endmodule

/* File: ditt_engine_tb.sv */
// self-checking bench for the trigger engine
`include "ditt_params.svh"
module ditt_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        i_clock = 1'b0;
  logic        i_rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        running;
  logic        rf_out;
  logic [7:0]  term;
  logic        cmp;
  logic        tbase;
  logic [31:0] chans;
  logic [7:0]  term_req = 8'h00;
  logic        cmp_req = 1'b0;
  logic [31:0] dval = 32'h0000_0000;
  logic [63:0] exp_q[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          seed = 32'hd7e8;
  always #2 i_clock = ~i_clock;
  ditt_module_model u_mod (.i_clock(i_clock), .i_term_req(term_req), .i_cmp_req(cmp_req), .i_data_req(dval),
    .o_terminal(term), .o_compare(cmp), .o_channels(chans), .o_timebase(tbase));
  ditt_engine dut (.i_clock(i_clock), .i_rstn(i_rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_module_function_terminal(term), .i_analog_compare(cmp), .i_ext_timebase(tbase), .i_channels(chans),
    .o_sample_clock_out(), .o_start_trigger_out(), .o_reference_trigger_out(rf_out), .o_running(running));
  // ==========================================================
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    $display("MISMATCH at %0t: wait timed out", $time);
    close_out();
  endtask
  // read answers are judged here against the oldest note, masked
  always @(posedge i_clock) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) begin
        timeout();
      end else begin
        check(prdata & exp_q[0][63:32], exp_q[0][31:0] & exp_q[0][63:32]);
        void'(exp_q.pop_front());
      end
    end
  end
  // ==========================================================
  // bus master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    if (!wr) exp_q.push_back({m, d});
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, ALL);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, e, m);
  endtask
  task automatic drain(input int n, input logic [31:0] e, input logic [31:0] m);
    repeat (n) rd(`DITT_DATA_OFS, e, m);
  endtask
  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (running !== v && n < lim) begin
      @(posedge i_clock);
      n++;
    end
    if (running !== v) timeout();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    dval = $random(seed);
    idle(6);
    i_rstn <= 1'b1;
    rd(`DITT_DIV_OFS, `DITT_DIV_RST, ALL);
    rd(`DITT_FLT_OFS, `DITT_FLT_RST, ALL);
    rd(12'h030, 32'h0000_0000, ALL);
    rd(12'h006, 32'h0000_0000, ALL);
    // software start, finite count of five
    wr(`DITT_DIV_OFS, 32'h0000_0001);
    wr(`DITT_COUNT_OFS, 32'h0000_0005);
    wr(`DITT_SRC_OFS, 32'h0000_0000);
    wr(`DITT_DELAY_OFS, 32'h0000_001E);
    wr(`DITT_CTRL_OFS, 32'h0000_0001);
    idle(20);
    check({31'b0, running}, 32'h0000_0000);
    wait_run(1'b1, 50);
    wait_run(1'b0, 500);
    rd(`DITT_STORED_OFS, 32'h0000_0005, ALL);
    drain(5, dval, ALL);
    wr(`DITT_DELAY_OFS, 32'h0000_0000);
    // continuous run into a full fifo, then stop and clear
    wr(`DITT_DIV_OFS, 32'h0000_0000);
    wr(`DITT_CTRL_OFS, 32'h0000_0021);
    idle(700);
    rd(`DITT_STATUS_OFS, 32'h0000_0014, 32'h0000_0014);
    wr(`DITT_CTRL_OFS, 32'h0000_0022);
    wait_run(1'b0, 50);
    wr(`DITT_CTRL_OFS, 32'h0000_0024);
    rd(`DITT_STATUS_OFS, 32'h0000_0000, 32'h0000_0004);
    drain(256, dval, ALL);
    rd(`DITT_STORED_OFS, 32'h0000_0000, ALL);
    // digital start on terminal 3 rising
    wr(`DITT_DIV_OFS, 32'h0000_0001);
    wr(`DITT_SRC_OFS, 32'h0000_000D);
    wr(`DITT_COUNT_OFS, 32'h0000_0003);
    wr(`DITT_CTRL_OFS, 32'h0000_0001);
    idle(20);
    check({31'b0, running}, 32'h0000_0000);
    term_req[3] <= 1'b1;
    wait_run(1'b1, 20);
    wait_run(1'b0, 200);
    rd(`DITT_STORED_OFS, 32'h0000_0003, ALL);
    drain(3, dval, ALL);
    term_req[3] <= 1'b0;
    // analog comparison start
    wr(`DITT_SRC_OFS, 32'h0000_0002);
    wr(`DITT_COUNT_OFS, 32'h0000_0002);
    wr(`DITT_CTRL_OFS, 32'h0000_0001);
    idle(20);
    check({31'b0, running}, 32'h0000_0000);
    cmp_req <= 1'b1;
    wait_run(1'b1, 20);
    wait_run(1'b0, 200);
    drain(2, dval, ALL);
    cmp_req <= 1'b0;
    // reference on terminal 5: early pulse ignored, buffer wraps, posttrigger stop
    wr(`DITT_DIV_OFS, 32'h0000_0014);
    wr(`DITT_COUNT_OFS, 32'h0000_0008);
    wr(`DITT_PRE_OFS, 32'h0000_0003);
    wr(`DITT_SRC_OFS, 32'h0000_02A0);
    wr(`DITT_CTRL_OFS, 32'h0000_0011);
    wait_run(1'b1, 50);
    term_req[5] <= 1'b1;
    idle(10);
    term_req[5] <= 1'b0;
    idle(900);
    check({31'b0, running}, 32'h0000_0001);
    check({31'b0, rf_out}, 32'h0000_0000);
    term_req[5] <= 1'b1;
    idle(10);
    term_req[5] <= 1'b0;
    wait_run(1'b0, 400);
    check({31'b0, rf_out}, 32'h0000_0001);
    rd(`DITT_STORED_OFS, 32'h0000_0008, ALL);
    rd(`DITT_STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
    drain(8, dval, ALL);
    wr(`DITT_CTRL_OFS, 32'h0000_1010);
    idle(2);
    check({31'b0, rf_out}, 32'h0000_0000);
    // time start, ended by software stop
    wr(`DITT_DIV_OFS, 32'h0000_0001);
    wr(`DITT_SRC_OFS, 32'h0000_0003);
    wr(`DITT_TIME_OFS, 32'h0000_4000);
    wr(`DITT_CTRL_OFS, 32'h0000_0021);
    idle(20);
    check({31'b0, running}, 32'h0000_0000);
    wait_run(1'b1, 20000);
    wr(`DITT_CTRL_OFS, 32'h0000_0022);
    wait_run(1'b0, 50);
    drain(256, dval, ALL);
    // pause on terminal 1, already active before the start
    wr(`DITT_SRC_OFS, 32'h0000_1400);
    term_req[1] <= 1'b1;
    wr(`DITT_CTRL_OFS, 32'h0000_0021);
    idle(40);
    rd(`DITT_STORED_OFS, 32'h0000_0000, ALL);
    rd(`DITT_STATUS_OFS, 32'h0000_0020, 32'h0000_0020);
    term_req[1] <= 1'b0;
    idle(40);
    rd(`DITT_STATUS_OFS, 32'h0000_0000, 32'h0000_0020);
    wr(`DITT_CTRL_OFS, 32'h0000_0820);
    idle(8);
    rd(`DITT_STATUS_OFS, 32'h0000_0020, 32'h0000_0020);
    wr(`DITT_CTRL_OFS, 32'h0000_0022);
    wait_run(1'b0, 50);
    close_out();
  end
endmodule
